// ===== hwm_reading_regs.sv
`timescale 1ns/1ps
module hwm_reading_regs
  import hwm_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYCLES_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire hwm_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic LOCK,
  input wire hwm_volt_t VOLT_RAW,
  input wire hwm_temp_t TEMP_RAW,
  input wire logic DIODE_ONE_FAULT,
  input wire logic DIODE_TWO_FAULT,
  output logic [7:0] ZONE1_TEMP,
  output logic [7:0] ZONE2_TEMP,
  output logic [7:0] ZONE3_TEMP,
  output logic [1:0] DIODE_FAULT_STATUS,
  output logic [7:0] VENDOR_TEST,
  output logic REFRESH_STROBE
);

  logic [7:0] test_q;
  logic [7:0] ofs_amb_q;
  logic [7:0] ofs_rtwo_q;
  logic [7:0] ofs_rone_q;
  hwm_volt_t volt_q;
  hwm_temp_t temp_q;
  logic [1:0] fault_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic tick;
  logic tick_q;
  logic [7:0] adj_rone;
  logic [7:0] adj_int;
  logic [7:0] adj_rtwo;
  logic wr_test;
  logic wr_ofs_amb;
  logic wr_ofs_rtwo;
  logic wr_ofs_rone;

  function automatic logic addr_defined(input logic [7:0] a);
    addr_defined = (a == ADDR_TEST) || (a >= ADDR_OFS_AMB && a <= ADDR_T_RTWO);
  endfunction : addr_defined

  function automatic logic addr_result(input logic [7:0] a);
    addr_result = (a >= ADDR_V2V5 && a <= ADDR_T_RTWO);
  endfunction : addr_result

  hwm_refresh_tick #(
    .PERIOD(REFRESH_CYCLES)
  ) u_tick (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .tick(tick)
  );

  hwm_temp_adj u_adj_rone (
    .raw(TEMP_RAW.remote_one),
    .offset(ofs_rone_q),
    .fault(DIODE_ONE_FAULT),
    .adj(adj_rone)
  );

  hwm_temp_adj u_adj_int (
    .raw(TEMP_RAW.internal),
    .offset(ofs_amb_q),
    .fault(1'b0),
    .adj(adj_int)
  );

  hwm_temp_adj u_adj_rtwo (
    .raw(TEMP_RAW.remote_two),
    .offset(ofs_rtwo_q),
    .fault(DIODE_TWO_FAULT),
    .adj(adj_rtwo)
  );

  always_comb begin
    wr_test = REG_REQ.wr && (REG_REQ.addr == ADDR_TEST);
    wr_ofs_amb = REG_REQ.wr && !LOCK && (REG_REQ.addr == ADDR_OFS_AMB);
    wr_ofs_rtwo = REG_REQ.wr && !LOCK && (REG_REQ.addr == ADDR_OFS_RTWO);
    wr_ofs_rone = REG_REQ.wr && !LOCK && (REG_REQ.addr == ADDR_OFS_RONE);
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      test_q <= RST_TEST;
    end else if (wr_test) begin
      test_q <= REG_REQ.wdata;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ofs_amb_q <= RST_OFS;
      ofs_rtwo_q <= RST_OFS;
      ofs_rone_q <= RST_OFS;
    end else begin
      if (wr_ofs_amb) begin
        ofs_amb_q <= REG_REQ.wdata;
      end
      if (wr_ofs_rtwo) begin
        ofs_rtwo_q <= REG_REQ.wdata;
      end
      if (wr_ofs_rone) begin
        ofs_rone_q <= REG_REQ.wdata;
      end
    end
  end

  // converter delivers already scaled unsigned codes
  // only the refresh tick loads results, never the host
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      volt_q <= '{default: RST_RESULT};
    end else if (tick) begin
      volt_q <= VOLT_RAW;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      temp_q <= '{default: RST_RESULT};
      fault_q <= 2'h0;
    end else if (tick) begin
      temp_q.remote_one <= adj_rone;
      temp_q.internal <= adj_int;
      temp_q.remote_two <= adj_rtwo;
      fault_q <= {DIODE_TWO_FAULT, DIODE_ONE_FAULT};
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick;
    end
  end

  // Read mux; a read sees the register value before any same-cycle write
  always_comb begin
    unique case (REG_REQ.addr)
      ADDR_TEST: rdata_d = test_q;
      ADDR_OFS_AMB: rdata_d = ofs_amb_q;
      ADDR_OFS_RTWO: rdata_d = ofs_rtwo_q;
      ADDR_OFS_RONE: rdata_d = ofs_rone_q;
      ADDR_V2V5: rdata_d = volt_q.v2v5;
      ADDR_CORE: rdata_d = volt_q.core;
      ADDR_OWN: rdata_d = volt_q.own;
      ADDR_V5: rdata_d = volt_q.v5;
      ADDR_V12: rdata_d = volt_q.v12;
      ADDR_T_RONE: rdata_d = temp_q.remote_one;
      ADDR_T_INT: rdata_d = temp_q.internal;
      ADDR_T_RTWO: rdata_d = temp_q.remote_two;
      default: rdata_d = UNDEF_READ;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= UNDEF_READ;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign ZONE1_TEMP = temp_q.remote_one;
  assign ZONE2_TEMP = temp_q.internal;
  assign ZONE3_TEMP = temp_q.remote_two;
  assign DIODE_FAULT_STATUS = fault_q;
  assign VENDOR_TEST = test_q;
  assign REFRESH_STROBE = tick_q;

  // Gap counter for the refresh bound check
  logic [31:0] gap_q;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      gap_q <= 32'h0;
    end else if (tick) begin
      gap_q <= 32'h0;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  undef_read_zero_a: assert property (
    REG_REQ.rd && !addr_defined(REG_REQ.addr) |=> REG_RVALID && REG_RDATA == UNDEF_READ)
    else $error("undefined read did not return zero");

  undef_write_a: assert property (
    REG_REQ.wr && !addr_defined(REG_REQ.addr)
      |=> $stable(test_q) && $stable(ofs_amb_q) && $stable(ofs_rtwo_q) && $stable(ofs_rone_q))
    else $error("undefined write changed state");

  test_lock_free_a: assert property (
    REG_REQ.wr && REG_REQ.addr == ADDR_TEST && LOCK |=> test_q == $past(REG_REQ.wdata))
    else $error("test register write lost under lock");

  offset_locked_a: assert property (
    REG_REQ.wr && LOCK && REG_REQ.addr >= ADDR_OFS_AMB && REG_REQ.addr <= ADDR_OFS_RONE
      |=> $stable(ofs_amb_q) && $stable(ofs_rtwo_q) && $stable(ofs_rone_q))
    else $error("offset changed while locked");

  offset_open_a: assert property (
    REG_REQ.wr && !LOCK && REG_REQ.addr == ADDR_OFS_RTWO |=> ofs_rtwo_q == $past(REG_REQ.wdata))
    else $error("unlocked offset write not stored");

  ambient_only_a: assert property (
    tick && ofs_rone_q == RST_OFS && !DIODE_ONE_FAULT && TEMP_RAW.remote_one != TEMP_FAULT
      |=> temp_q.remote_one == $past(TEMP_RAW.remote_one))
    else $error("ambient offset leaked into remote one");

  remote_read_a: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_T_RONE |=> REG_RDATA == $past(temp_q.remote_one))
    else $error("remote one read wrong");

  zero_offset_a: assert property (
    tick && ofs_rtwo_q == RST_OFS && !DIODE_TWO_FAULT
      |=> temp_q.remote_two == $past(TEMP_RAW.remote_two))
    else $error("zero offset altered remote two");

  volt_order_a: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_V5 |=> REG_RDATA == $past(volt_q.v5))
    else $error("voltage register order wrong");

  refresh_bound_a: assert property (
    gap_q < 32'(REFRESH_CYCLES))
    else $error("result refresh gap too long");

  ro_write_a: assert property (
    REG_REQ.wr && addr_result(REG_REQ.addr) && !tick |=> $stable(volt_q) && $stable(temp_q))
    else $error("host write changed a result");

  fault_code_a: assert property (
    tick && DIODE_ONE_FAULT
      |=> temp_q.remote_one == TEMP_FAULT && DIODE_FAULT_STATUS[0] && ZONE1_TEMP == TEMP_FAULT)
    else $error("diode fault code not loaded");

  zone_map_a: assert property (
    tick_q |-> ZONE1_TEMP == $past(adj_rone) && ZONE2_TEMP == $past(adj_int) && ZONE3_TEMP == $past(adj_rtwo))
    else $error("zone mapping wrong");

  clamp_range_a: assert property (
    tick && !DIODE_TWO_FAULT && TEMP_RAW.remote_two != TEMP_FAULT |=> temp_q.remote_two != TEMP_FAULT)
    else $error("offset produced fault code");

  clamp_high_a: assert property (
    tick && !TEMP_RAW.internal[7] && !ofs_amb_q[7]
      && ({1'b0, TEMP_RAW.internal} + {1'b0, ofs_amb_q}) > {1'b0, TEMP_MAX} |=> temp_q.internal == TEMP_MAX)
    else $error("positive clamp failed");

  clamp_low_a: assert property (
    tick && TEMP_RAW.remote_one[7] && ofs_rone_q[7] && !DIODE_ONE_FAULT && TEMP_RAW.remote_one != TEMP_FAULT
      |=> temp_q.remote_one[7] && temp_q.remote_one != TEMP_FAULT)
    else $error("negative clamp failed");

  volt_load_a: assert property (
    tick |=> volt_q == $past(VOLT_RAW))
    else $error("voltage code not loaded as delivered");

  volt_first_a: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_V2V5 |=> REG_RDATA == $past(volt_q.v2v5))
    else $error("first voltage register wrong");

  internal_offset_a: assert property (
    tick && ofs_amb_q == RST_OFS |=> temp_q.internal == $past(TEMP_RAW.internal))
    else $error("zero ambient offset altered internal");

  remote_two_read_a: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_T_RTWO |=> REG_RDATA == $past(temp_q.remote_two))
    else $error("remote two read wrong");

  fault_two_a: assert property (
    tick && DIODE_TWO_FAULT |=> temp_q.remote_two == TEMP_FAULT && DIODE_FAULT_STATUS[1])
    else $error("diode two fault code not loaded");

  test_readback_a: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_TEST |=> REG_RDATA == $past(VENDOR_TEST))
    else $error("test register read wrong");

  offset_readback_a: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_OFS_AMB |=> REG_RDATA == $past(ofs_amb_q))
    else $error("ambient offset read wrong");

  strobe_after_a: assert property (
    tick |=> REFRESH_STROBE)
    else $error("refresh strobe missing after load");

  int_read_a: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_T_INT |=> REG_RDATA == $past(ZONE2_TEMP))
    else $error("internal result read wrong");

  cover_locked_write_c: cover property (
    REG_REQ.wr && LOCK && REG_REQ.addr == ADDR_OFS_AMB);

  cover_fault_c: cover property (tick && DIODE_TWO_FAULT ##1 REFRESH_STROBE);

  cover_nominal_c: cover property (tick && VOLT_RAW.own == VOLT_NOMINAL);

  cover_full_c: cover property (tick && VOLT_RAW.v12 == VOLT_FULL);

  cover_undef_read_c: cover property (REG_REQ.rd && REG_REQ.addr == 8'h28);

endmodule : hwm_reading_regs

// ===== hwm_pkg.sv
package hwm_pkg;

  // Register map
  localparam logic [7:0] ADDR_TEST = 8'h10;
  localparam logic [7:0] ADDR_OFS_AMB = 8'h1d;
  localparam logic [7:0] ADDR_OFS_RTWO = 8'h1e;
  localparam logic [7:0] ADDR_OFS_RONE = 8'h1f;
  localparam logic [7:0] ADDR_V2V5 = 8'h20;
  localparam logic [7:0] ADDR_CORE = 8'h21;
  localparam logic [7:0] ADDR_OWN = 8'h22;
  localparam logic [7:0] ADDR_V5 = 8'h23;
  localparam logic [7:0] ADDR_V12 = 8'h24;
  localparam logic [7:0] ADDR_T_RONE = 8'h25;
  localparam logic [7:0] ADDR_T_INT = 8'h26;
  localparam logic [7:0] ADDR_T_RTWO = 8'h27;

  // Values after reset and fixed codes
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] UNDEF_READ = 8'h00;
  localparam logic [7:0] TEMP_FAULT = 8'h80;
  localparam logic [7:0] TEMP_MAX = 8'h7f;
  localparam logic [7:0] TEMP_MIN = 8'h81;
  localparam logic [7:0] VOLT_NOMINAL = 8'hc0;
  localparam logic [7:0] VOLT_FULL = 8'hff;

  // Refresh timing: longest allowed gap rounds down to whole cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int REFRESH_MIN_HZ = 4;
  localparam int REFRESH_PERIOD_NS = 1000000000 / REFRESH_MIN_HZ;
  localparam int REFRESH_CYCLES_DEF = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hwm_req_t;

  typedef struct packed {
    logic [7:0] v2v5;
    logic [7:0] core;
    logic [7:0] own;
    logic [7:0] v5;
    logic [7:0] v12;
  } hwm_volt_t;

  typedef struct packed {
    logic [7:0] remote_one;
    logic [7:0] internal;
    logic [7:0] remote_two;
  } hwm_temp_t;

endpackage : hwm_pkg

// ===== hwm_temp_adj.sv
`timescale 1ns/1ps
module hwm_temp_adj
  import hwm_pkg::*;
(
  input wire logic [7:0] raw,
  input wire logic [7:0] offset,
  input wire logic fault,
  output logic [7:0] adj
);

  logic signed [8:0] sum;

  always_comb begin
    sum = $signed({raw[7], raw}) + $signed({offset[7], offset});
    if (fault || raw == TEMP_FAULT) begin
      adj = TEMP_FAULT;
    end else if (sum > $signed({1'b0, TEMP_MAX})) begin
      adj = TEMP_MAX;
    end else if (sum < $signed({1'b1, TEMP_MIN})) begin
      // Clamp to -127 so an offset never fakes the sensor error code
      adj = TEMP_MIN;
    end else begin
      adj = sum[7:0];
    end
  end

endmodule : hwm_temp_adj

// ===== hwm_refresh_tick.sv
`timescale 1ns/1ps
module hwm_refresh_tick #(
  parameter int PERIOD = 16
) (
  input wire logic clk,
  input wire logic rstn,
  output logic tick
);

  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick = (cnt_q == LAST);

endmodule : hwm_refresh_tick

// ===== hwm_host_model.sv
`timescale 1ns/1ps
module hwm_host_model
  import hwm_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output hwm_req_t req
);
  initial req = '0;

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    if (a != ADDR_TEST) begin
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    end
    @(posedge clk);
    #1;
    req = '0;
  endtask : write_reg

  // Read data is due right after the same edge that takes the request
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    #1;
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    ok = rvalid;
    d = rdata;
    req = '0;
  endtask : read_reg
endmodule : hwm_host_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hwm_pkg::*;
  localparam int RC = 16;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  hwm_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic lock = 1'b0;
  hwm_volt_t volt = '0;
  hwm_temp_t temp = '0;
  logic f_one = 1'b0;
  logic f_two = 1'b0;
  logic [7:0] z1, z2, z3, vtest;
  logic [1:0] fstat;
  logic strobe;
  int err_total = 0;
  int n_tests = 0;

  always #25 clk_sys = ~clk_sys;

  hwm_reading_regs #(.REFRESH_CYCLES(RC)) uut (
    .CLK_SYS(clk_sys), .RSTN(rstn), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .LOCK(lock), .VOLT_RAW(volt), .TEMP_RAW(temp), .DIODE_ONE_FAULT(f_one),
    .DIODE_TWO_FAULT(f_two), .ZONE1_TEMP(z1), .ZONE2_TEMP(z2), .ZONE3_TEMP(z3),
    .DIODE_FAULT_STATUS(fstat), .VENDOR_TEST(vtest), .REFRESH_STROBE(strobe)
  );

  hwm_host_model host (.clk(clk_sys), .rdata(rdata), .rvalid(rvalid), .req(req));

  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_reg(a, d, ok);
    check("read valid", {7'h00, ok}, 8'h01);
    check($sformatf("reg %h", a), d, exp);
  endtask : rd_chk

  // Two strobes, so the second load surely saw the new inputs; n is the gap
  task automatic two_refresh(output int n);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n++;
        if (n > 3 * RC) begin
          err_total++;
          $display("mismatch refresh strobe expected 1 seen 0");
          wrap_up();
        end
      end while (strobe !== 1'b1);
    end
  endtask : two_refresh

  task automatic t_reset;
    check("vendor test", vtest, RST_TEST);
    rd_chk(ADDR_TEST, RST_TEST);
    rd_chk(ADDR_OFS_AMB, RST_OFS);
    rd_chk(ADDR_OFS_RTWO, RST_OFS);
    rd_chk(ADDR_OFS_RONE, RST_OFS);
    $display("test reset done");
  endtask : t_reset

  task automatic t_undef;
    host.write_reg(8'h15, 8'ha5);
    host.write_reg(8'h11, 8'h5a);
    rd_chk(8'h15, UNDEF_READ);
    rd_chk(8'h28, UNDEF_READ);
    rd_chk(8'hff, UNDEF_READ);
    rd_chk(ADDR_OFS_RONE, RST_OFS);
    check("vendor test", vtest, RST_TEST);
    $display("test undefined done");
  endtask : t_undef

  task automatic t_volt;
    int n;
    volt = '{v2v5: VOLT_NOMINAL, core: 8'h00, own: VOLT_FULL, v5: 8'h3c, v12: 8'h9a};
    temp = '{remote_one: 8'h32, internal: 8'hce, remote_two: TEMP_MAX};
    two_refresh(n);
    check("refresh gap", 8'(n), 8'(RC));
    rd_chk(ADDR_V2V5, VOLT_NOMINAL);
    rd_chk(ADDR_CORE, 8'h00);
    rd_chk(ADDR_OWN, VOLT_FULL);
    rd_chk(ADDR_V5, 8'h3c);
    rd_chk(ADDR_V12, 8'h9a);
    host.write_reg(ADDR_CORE, 8'h55);
    host.write_reg(ADDR_T_INT, 8'h55);
    rd_chk(ADDR_CORE, 8'h00);
    rd_chk(ADDR_T_INT, 8'hce);
    rd_chk(ADDR_T_RONE, 8'h32);
    check("zone one", z1, 8'h32);
    check("zone two", z2, 8'hce);
    check("zone three", z3, TEMP_MAX);
    $display("test voltage done");
  endtask : t_volt

  task automatic t_offset;
    int n;
    host.write_reg(ADDR_OFS_AMB, 8'h05);
    host.write_reg(ADDR_OFS_RTWO, 8'hfb);
    host.write_reg(ADDR_OFS_RONE, 8'h80);
    temp = '{remote_one: 8'h81, internal: 8'h10, remote_two: 8'h7d};
    two_refresh(n);
    rd_chk(ADDR_T_RONE, TEMP_MIN);
    rd_chk(ADDR_T_INT, 8'h15);
    rd_chk(ADDR_T_RTWO, 8'h78);
    temp = '{remote_one: 8'h32, internal: 8'h7e, remote_two: 8'h00};
    two_refresh(n);
    check("zone one", z1, 8'hb2);
    check("zone two", z2, TEMP_MAX);
    check("zone three", z3, 8'hfb);
    $display("test offset done");
  endtask : t_offset

  task automatic t_fault_lock;
    int n;
    f_one = 1'b1;
    two_refresh(n);
    rd_chk(ADDR_T_RONE, TEMP_FAULT);
    check("fault status", {6'h00, fstat}, 8'h01);
    check("zone three", z3, 8'hfb);
    f_one = 1'b0;
    f_two = 1'b1;
    two_refresh(n);
    check("zone three", z3, TEMP_FAULT);
    check("fault status", {6'h00, fstat}, 8'h02);
    f_two = 1'b0;
    lock = 1'b1;
    host.write_reg(ADDR_OFS_AMB, 8'h33);
    rd_chk(ADDR_OFS_AMB, 8'h05);
    lock = 1'b0;
    host.write_reg(ADDR_OFS_AMB, 8'h33);
    rd_chk(ADDR_OFS_AMB, 8'h33);
    host.write_reg(ADDR_OFS_RONE, 8'h00);
    two_refresh(n);
    check("zone one", z1, 8'h32);
    check("zone two", z2, TEMP_MAX);
    $display("test fault and lock done");
  endtask : t_fault_lock

  // Ambient and remote two offsets were loaded before this reset, so a zero read proves the reset for those two
  task automatic t_mid_reset;
    int n;
    @(posedge clk_sys);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    t_reset();
    two_refresh(n);
    check("zone two", z2, 8'h7e);
    check("zone three", z3, 8'h00);
    $display("test mid reset done");
  endtask : t_mid_reset

  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    t_reset();
    t_undef();
    t_volt();
    t_offset();
    t_fault_lock();
    t_mid_reset();
    wrap_up();
  end
endmodule : tb_top
